// ===== shared/ldf_pkg.sv
// Purpose: shared constants for the led row supervision logic
// Assumes: 125 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derived here
package ldf_pkg;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned ROWS           = 6;
    localparam int unsigned SHORT_MASK_US  = 100;
    localparam int unsigned SHORT_MASK_CYC = SHORT_MASK_US * CLK_MHZ;
    localparam int unsigned MASK_W         = 14;
    localparam logic [MASK_W-1:0] MASK_LAST = MASK_W'(SHORT_MASK_CYC - 1);
    localparam logic [ROWS-1:0] ROWS_ZERO  = 6'h00;
    localparam logic [ROWS-1:0] ROWS_ALL   = 6'h3f;

    typedef enum logic [2:0] {
        LDF_OFF     = 3'b000,
        LDF_START   = 3'b001,
        LDF_RUN     = 3'b010,
        LDF_LATCHED = 3'b011,
        LDF_THERMAL = 3'b100
    } ldf_state_e;
endpackage

// ===== src/ldf_sync.sv
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: single clock, synchronous active-high reset
// Notes:   first stage read only by the second stage
`timescale 1ns/100ps
module ldf_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ldf_sync_s;

    ldf_sync_s r_q;
    ldf_sync_s r_d;

    // shift through two stages
    always_comb begin
        r_d.meta = i_async;
        r_d.sync = r_q.meta;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_sync = r_q.sync;
endmodule

// ===== src/ldf_supervisor.sv
// Purpose: dimming gate and fault policy for a six-row led driver
// Assumes: comparator and strap inputs are synchronised here
// Notes:   analog loop, current set and current limit are outside
`timescale 1ns/100ps
module ldf_supervisor
    import ldf_pkg::*;
(
    input  wire logic            i_clk_sys,
    input  wire logic            i_sys_rst,
    input  wire logic            i_enable,
    input  wire logic            i_brightness_pwm_in,
    input  wire logic            i_policy_high,
    input  wire logic            i_overtemp,
    input  wire logic            i_temp_recovered,
    input  wire logic            i_overvoltage_sense,
    input  wire logic            i_softstart_done,
    input  wire logic [ROWS-1:0] i_row_open,
    input  wire logic [ROWS-1:0] i_row_short,
    output logic      [ROWS-1:0] o_row_on,
    output logic                 o_boost_run,
    output logic                 o_ldo_on,
    output logic                 o_softstart_run,
    output logic                 o_fault_out,
    output logic                 o_fault_oe_n,
    output logic      [ROWS-1:0] o_row_excluded
);
    localparam int SW = 2 * ROWS + 6;

    // all inputs except i_softstart_done cross into the clock domain first
    logic [SW-1:0] sync_w;
    ldf_sync #(.W(SW)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_enable, i_brightness_pwm_in, i_policy_high, i_overtemp,
                     i_temp_recovered, i_overvoltage_sense, i_row_open, i_row_short}),
        .o_sync    (sync_w)
    );

    logic            en_s;
    logic            pwm_s;
    logic            pol_s;
    logic            ot_s;
    logic            trec_s;
    logic            ov_s;
    logic [ROWS-1:0] open_s;
    logic [ROWS-1:0] short_s;
    assign {en_s, pwm_s, pol_s, ot_s, trec_s, ov_s, open_s, short_s} = sync_w;

    typedef struct packed {
        ldf_state_e      st;
        logic            pwm_prev;
        logic            ov_pause;
        logic [MASK_W-1:0] mask_cnt;
        logic [ROWS-1:0] excl;
        logic [ROWS-1:0] row_on;
        logic            boost;
        logic            ss_run;
        logic            ldo;
        logic            fault_oe_n;
    } ldf_s;

    ldf_s r_q;
    ldf_s r_d;

    logic [ROWS-1:0] live_short;
    logic            mask_done;
    assign live_short = short_s & ~r_q.excl;
    assign mask_done  = (r_q.mask_cnt == MASK_LAST);

    // rows left in the loop once disconnected ones are taken out
    function automatic logic [ROWS-1:0] kept_rows(input logic [ROWS-1:0] ex);
        return ROWS_ALL & ~ex;
    endfunction

    // one next-state process; thermal overrides everything but an enable drop
    always_comb begin
        r_d          = r_q;
        r_d.pwm_prev = pwm_s;
        // overvoltage: pause until sense falls below lower threshold (hysteresis in comparator)
        r_d.ov_pause = ov_s;
        case (r_q.st)
            LDF_OFF: begin
                r_d.excl     = ROWS_ZERO;
                r_d.mask_cnt = '0;
                if (en_s) begin
                    r_d.st = LDF_START;
                end
            end
            LDF_START: begin
                // no stale mask count may survive into run
                r_d.mask_cnt = '0;
                // floating rows seen at full duty; a latch must beat soft-start done
                if (|open_s && !pol_s) begin
                    r_d.st = LDF_LATCHED;
                end else begin
                    if (|open_s) begin
                        r_d.excl = r_q.excl | open_s;
                    end
                    if (i_softstart_done) begin
                        r_d.st = LDF_RUN;
                    end
                end
            end
            LDF_RUN: begin
                // mask counter: restart on new on phase, clear when short gone
                if (pol_s || live_short == ROWS_ZERO ||
                    (pwm_s && !r_q.pwm_prev)) begin
                    r_d.mask_cnt = '0;
                end else if (pwm_s && !mask_done) begin
                    r_d.mask_cnt = r_q.mask_cnt + 1'b1;
                end
                if (!pol_s && mask_done && live_short != ROWS_ZERO) begin
                    r_d.st = LDF_LATCHED;
                end
                if (|(open_s & ~r_q.excl)) begin
                    if (pol_s) begin
                        r_d.excl = r_q.excl | open_s;
                    end else begin
                        r_d.st = LDF_LATCHED;
                    end
                end
            end
            LDF_LATCHED: begin
                // only an enable drop or an overtemp (into thermal) releases the latch
                r_d.mask_cnt = '0;
            end
            LDF_THERMAL: begin
                r_d.mask_cnt = '0;
                if (trec_s) begin
                    r_d.st = LDF_START;
                end
            end
            default: begin
                r_d.st = LDF_OFF;
            end
        endcase
        if (!en_s) begin
            r_d.st = LDF_OFF;
        end else if (ot_s) begin
            r_d.st = LDF_THERMAL;
        end
        // outputs from next state so they land in flops
        r_d.ss_run    = (r_d.st == LDF_START);
        r_d.fault_oe_n = !((r_d.st == LDF_THERMAL) || (r_d.st == LDF_LATCHED));
        // ldo tracks enable alone; thermal does not touch it
        r_d.ldo       = en_s;
        case (r_d.st)
            LDF_START: begin
                r_d.row_on = kept_rows(r_d.excl);
                r_d.boost  = !ov_s;
            end
            LDF_RUN: begin
                r_d.row_on = pwm_s ? kept_rows(r_d.excl) : ROWS_ZERO;
                r_d.boost  = pwm_s && !ov_s;
            end
            default: begin
                r_d.row_on = ROWS_ZERO;
                r_d.boost  = 1'b0;
            end
        endcase
    end

    // fault line released during reset, everything else off
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            r_q <= '{st: LDF_OFF, fault_oe_n: 1'b1, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    assign o_row_on        = r_q.row_on;
    assign o_boost_run     = r_q.boost;
    assign o_ldo_on        = r_q.ldo;
    assign o_softstart_run = r_q.ss_run;
    assign o_fault_out     = 1'b0; // open collector only ever pulls low
    assign o_fault_oe_n    = r_q.fault_oe_n;
    assign o_row_excluded  = r_q.excl;

    // checks
    thermal_off_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        r_q.st == LDF_THERMAL |-> !o_boost_run && o_row_on == ROWS_ZERO && !o_fault_oe_n)
        else $error("thermal not shut down");
    thermal_back_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        r_q.st == LDF_THERMAL && trec_s && en_s && !ot_s |=> r_q.st == LDF_START)
        else $error("no thermal recovery");
    ldo_alive_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        r_q.st == LDF_THERMAL |-> o_ldo_on)
        else $error("ldo dropped in thermal");
    pwm_off_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        r_q.st == LDF_RUN && r_d.st == LDF_RUN && !pwm_s |=> o_row_on == ROWS_ZERO && !o_boost_run)
        else $error("rows on in off phase");
    start_full_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        r_q.st == LDF_START |-> o_row_on == (ROWS_ALL & ~r_q.excl))
        else $error("start not full duty");
    short_latch_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        r_q.st == LDF_RUN && en_s && !ot_s && !pol_s && mask_done && live_short != ROWS_ZERO
        |=> r_q.st == LDF_LATCHED && !o_fault_oe_n)
        else $error("short not latched");
    policy_high_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        pol_s && r_q.st == LDF_RUN && !ot_s && en_s |=> r_q.st != LDF_LATCHED)
        else $error("latched under high policy");
    mask_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        live_short == ROWS_ZERO |=> r_q.mask_cnt == '0)
        else $error("mask not cleared");
    mask_restart_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        r_q.st == LDF_RUN && pwm_s && !r_q.pwm_prev |=> r_q.mask_cnt == '0)
        else $error("mask not restarted");
    enable_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !en_s |=> r_q.st == LDF_OFF && o_fault_oe_n)
        else $error("enable drop did not clear");
    cv_run_c: cover property (@(posedge i_clk_sys) r_q.st == LDF_START ##1 r_q.st == LDF_RUN);
    cv_latch_c: cover property (@(posedge i_clk_sys) r_q.st == LDF_LATCHED);
    cv_therm_c: cover property (@(posedge i_clk_sys) r_q.st == LDF_THERMAL ##1 r_q.st == LDF_START);
    cv_excl_c: cover property (@(posedge i_clk_sys) r_q.excl != ROWS_ZERO && r_q.st == LDF_RUN);
endmodule

// ===== bench/ldf_host_model.sv
// Purpose: host side, dimming pwm source and fault line reader
// Assumes: fault line pulled up on the board
// Notes:   an on phase is never cut shorter than ON_MIN cycles
`timescale 1ns/100ps
module ldf_host_model #(
    parameter int ON_MIN = 1250
) (
    input  wire logic i_clk_sys,
    input  wire logic i_pwm_req,
    input  wire logic i_fault_out,
    input  wire logic i_fault_oe_n,
    output logic      o_brightness_pwm_in,
    output logic      o_fault_line
);
    int on_cnt = 0;
    initial o_brightness_pwm_in = 1'b0;
    // short on phases starve the boost loop, so requests wait
    always @(posedge i_clk_sys) begin
        if (o_brightness_pwm_in && on_cnt < ON_MIN) begin
            on_cnt <= on_cnt + 1;
        end else begin
            o_brightness_pwm_in <= i_pwm_req;
            on_cnt              <= 0;
        end
    end
    // released line reads high through the pull-up
    assign o_fault_line = i_fault_oe_n ? 1'b1 : i_fault_out;
endmodule

// ===== bench/led_driver_fault_dimming_control_test.sv
// Purpose: self-checking bench for the row supervision logic
// Assumes: 125 MHz clock, fault line pulled up
// Notes:   mask count is full length, so the short case runs long
`timescale 1ns/100ps
module led_driver_fault_dimming_control_test;
    import ldf_pkg::*;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            en = 1'b0, pol = 1'b0, ot = 1'b0, tr = 1'b0;
    logic            ov = 1'b0, ssd = 1'b0, req = 1'b0;
    logic [ROWS-1:0] ropen = ROWS_ZERO, rshort = ROWS_ZERO, r;
    logic [ROWS-1:0] row_on, rexc;
    logic            boost, ldo, ssr, fout, foe_n, pwm, fline;
    int              errors = 0, n_checks = 0;
    int              seed = 32'hacb9;

    ldf_supervisor dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_enable(en),
        .i_brightness_pwm_in(pwm), .i_policy_high(pol), .i_overtemp(ot),
        .i_temp_recovered(tr), .i_overvoltage_sense(ov), .i_softstart_done(ssd),
        .i_row_open(ropen), .i_row_short(rshort), .o_row_on(row_on),
        .o_boost_run(boost), .o_ldo_on(ldo), .o_softstart_run(ssr),
        .o_fault_out(fout), .o_fault_oe_n(foe_n), .o_row_excluded(rexc));
    ldf_host_model host (.i_clk_sys(clk), .i_pwm_req(req), .i_fault_out(fout),
        .i_fault_oe_n(foe_n), .o_brightness_pwm_in(pwm), .o_fault_line(fline));

    always #4 clk = ~clk;

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [5:0] seen, input logic [5:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // rows expected for a pwm level with some rows disconnected
    function automatic logic [ROWS-1:0] exp_rows(logic p, logic [ROWS-1:0] ex);
        return p ? (ROWS_ALL & ~ex) : ROWS_ZERO;
    endfunction
    function automatic logic [ROWS-1:0] pick();
        return 6'h01 << ($unsigned($random(seed)) % ROWS);
    endfunction

    // hang guard, well past the longest expected run
    initial begin
        wt(40000);
        errors++;
        wrap_up;
    end

    // main sequence: start, dimming, ov, open, thermal, latches
    initial begin
        wt(2);
        rst <= 1'b0;
        #1;
        chk("fault idle", 6'(fline), 6'h01);
        wt(1);
        pol <= 1'b1;
        en  <= 1'b1;
        wt(6);
        #1;
        chk("start rows", row_on, ROWS_ALL);
        chk("start flag", 6'(ssr), 6'h01);
        chk("ldo on", 6'(ldo), 6'h01);
        wt(1);
        ssd    <= 1'b1;
        rshort <= pick();
        wt(6);
        #1;
        chk("off rows", row_on, ROWS_ZERO);
        chk("off boost", 6'(boost), 6'h00);
        chk("run flag", 6'(ssr), 6'h00);
        for (int i = 0; i < 6; i++) begin
            wt(1);
            req <= 1'($random(seed));
            wt(1300);
            #1;
            chk("pwm rows", row_on, exp_rows(pwm, ROWS_ZERO));
            chk("pwm boost", 6'(boost), 6'(pwm));
            chk("short ignored", 6'(fline), 6'h01);
        end
        wt(1);
        req <= 1'b1;
        ov  <= 1'b1;
        wt(6);
        #1;
        chk("ov boost", 6'(boost), 6'h00);
        wt(1);
        ov <= 1'b0;
        wt(6);
        #1;
        chk("ov resume", 6'(boost), 6'h01);
        chk("on rows", row_on, ROWS_ALL);
        wt(1);
        r = pick();
        ropen <= r;
        wt(6);
        #1;
        chk("excluded", rexc, r);
        chk("kept rows", row_on, exp_rows(1'b1, r));
        chk("open released", 6'(fline), 6'h01);
        wt(1);
        ropen <= ROWS_ZERO;
        ssd   <= 1'b0;
        ot    <= 1'b1;
        wt(6);
        #1;
        chk("hot rows", row_on, ROWS_ZERO);
        chk("hot boost", 6'(boost), 6'h00);
        chk("hot fault", 6'(fline), 6'h00);
        chk("hot ldo", 6'(ldo), 6'h01);
        wt(1);
        ot <= 1'b0;
        tr <= 1'b1;
        wt(6);
        #1;
        chk("cool restart", 6'(ssr), 6'h01);
        chk("cool fault", 6'(fline), 6'h01);
        wt(1);
        tr     <= 1'b0;
        en     <= 1'b0;
        rshort <= ROWS_ZERO;
        wt(4);
        pol <= 1'b0;
        wt(2);
        en    <= 1'b1;
        ropen <= pick();
        wt(6);
        #1;
        chk("open latch", 6'(fline), 6'h00);
        chk("latch rows", row_on, ROWS_ZERO);
        wt(1);
        ropen <= ROWS_ZERO;
        wt(8);
        #1;
        chk("latch holds", 6'(fline), 6'h00);
        wt(1);
        en <= 1'b0;
        wt(6);
        #1;
        chk("latch cleared", 6'(fline), 6'h01);
        chk("ldo off", 6'(ldo), 6'h00);
        wt(1);
        en     <= 1'b1;
        rshort <= pick();
        wt(6);
        ssd <= 1'b1;
        wt(12000);
        #1;
        chk("short masked", 6'(fline), 6'h01);
        wt(600);
        #1;
        chk("short latch", 6'(fline), 6'h00);
        chk("short rows", row_on, ROWS_ZERO);
        wrap_up;
    end
endmodule
